/* logic/sdp_port.sv */
// Serial wire debug port: pin muxing, line reset and packet engine
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module sdp_port
    import sdp_pkg::*;
#(
    // Arbitrary identification value, not a real part code
    parameter logic [31:0] ID_VALUE = 32'h1234_5671
)
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [1:0]  prot_level,
    input  wire logic        debug_clock_pin,
    input  wire logic        debug_data_in,
    output logic             debug_data_out,
    output logic             debug_data_oe,
    output logic             debug_port_enable,
    output logic             gpio_pin_enable,
    output logic             boot_path_enable,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [31:0]      reg_rdata,
    output logic             acc_write,
    output logic             acc_read,
    output logic             acc_ap,
    output logic [1:0]       acc_addr,
    output logic [31:0]      acc_wdata,
    input  wire logic        core_ready,
    input  wire logic        core_fault,
    input  wire logic [31:0] core_rdata,
    output logic             port_active
);
    if (ID_VALUE == 32'h0000_0000)
    begin : g_bad_id
        $error("ID_VALUE must not be zero");
    end

    //======================================================================
    // Pin function and protection
    //======================================================================
    logic pin_select;
    logic orun_en;
    logic parity_error;
    logic perr_set;

    wire level_ok   = prot_level < SDP_LEVEL_NO_PORT;
    wire port_en    = !pin_select && level_ok;
    assign debug_port_enable = port_en;
    assign gpio_pin_enable   = pin_select;
    assign boot_path_enable  = pin_select
                               && prot_level != SDP_LEVEL_LOCKED;

    sdp_regs u_regs (
        .clk                   (clk),
        .reset                 (reset),
        .reg_addr              (reg_addr),
        .reg_wdata             (reg_wdata),
        .reg_write             (reg_write),
        .reg_read              (reg_read),
        .reg_rdata             (reg_rdata),
        .pin_select            (pin_select),
        .overrun_detect_enable (orun_en),
        .port_active           (port_active),
        .port_enable           (port_en),
        .parity_error_set      (perr_set),
        .parity_error          (parity_error)
    );

    //======================================================================
    // Link sampling
    //======================================================================
    logic swclk;
    logic swdio;
    logic swclk_q;

    // Clock and data see the same latency, so their relation is kept
    sdp_sync u_sync_clk (
        .clk   (clk),
        .reset (reset),
        .pin   (debug_clock_pin),
        .level (swclk)
    );
    sdp_sync u_sync_dat (
        .clk   (clk),
        .reset (reset),
        .pin   (debug_data_in),
        .level (swdio)
    );

    // Inputs sampled on the link rising edge, outputs launched there too
    // so the host samples them just before the next rising edge
    wire rise = swclk && !swclk_q;

    //======================================================================
    // Packet engine
    //======================================================================
    sdp_state_t state;
    logic [5:0]  cnt;
    logic [5:0]  high_cnt;
    logic [1:0]  low_cnt;
    logic [7:0]  req;
    logic [32:0] sh;
    logic [2:0]  ack;
    logic        req_rnw;
    logic        data_phase;

    function automatic logic even_parity(input logic [31:0] v);
        even_parity = ^v;
    endfunction : even_parity

    wire [7:0] next_req  = {swdio, req[7:1]};
    wire [32:0] next_sh  = {swdio, sh[32:1]};
    wire req_good  = next_req[SDP_REQ_START]
                     && !next_req[SDP_REQ_STOP]
                     && next_req[SDP_REQ_PARK]
                     && ^next_req[SDP_REQ_PARITY:0] == 1'b0;
    wire is_id     = !acc_ap && req_rnw && acc_addr == 2'h0;
    wire refuse    = !port_active && !is_id;
    wire [2:0] next_ack = is_id      ? SDP_ACK_OK    :
                          core_fault ? SDP_ACK_FAULT :
                          core_ready ? SDP_ACK_OK    : SDP_ACK_WAIT;
    wire ack_ok     = next_ack == SDP_ACK_OK;
    wire next_data  = ack_ok || orun_en;
    wire [31:0] rd_word = !ack_ok ? 32'h0000_0000 :
                          is_id   ? ID_VALUE : core_rdata;
    wire wr_par_ok  = even_parity(next_sh[31:0]) == next_sh[32];
    wire line_reset = !debug_data_oe && swdio
                      && high_cnt >= SDP_LINE_RESET;
    wire [5:0] high_inc = high_cnt + 6'h01;

    always_ff @(posedge clk)
    begin
        if (reset)
            swclk_q <= 1'b1;
        else
            swclk_q <= swclk;
    end

    // Run of high samples while the line is not ours
    always_ff @(posedge clk)
    begin
        if (reset || !port_en)
            high_cnt <= 6'h00;
        else if (rise)
            high_cnt <= (swdio && !debug_data_oe)
                        ? (line_reset ? high_cnt : high_inc) : 6'h00;
    end

    always_ff @(posedge clk)
    begin
        if (reset || !port_en)
        begin
            state          <= ST_RESET;
            cnt            <= 6'h00;
            low_cnt        <= 2'h0;
            req            <= 8'h00;
            sh             <= 33'h0_0000_0000;
            ack            <= SDP_ACK_WAIT;
            req_rnw        <= 1'b0;
            data_phase     <= 1'b0;
            acc_ap         <= 1'b0;
            acc_addr       <= 2'h0;
            debug_data_out <= 1'b1;
            debug_data_oe  <= 1'b0;
            port_active    <= 1'b0;
        end
        else if (rise && line_reset)
        begin
            state         <= ST_RESET;
            low_cnt       <= 2'h0;
            debug_data_oe <= 1'b0;
            port_active   <= 1'b0;
        end
        else if (rise)
        begin
            unique case (state)
                ST_RESET:
                begin
                    low_cnt <= swdio ? 2'h0 : low_cnt + 2'h1;
                    if (!swdio && low_cnt == SDP_IDLE_LOWS - 2'h1)
                        state <= ST_IDLE;
                end
                ST_IDLE:
                begin
                    req <= next_req;
                    cnt <= 6'h01;
                    if (swdio)
                        state <= ST_REQ;
                end
                ST_REQ:
                begin
                    req     <= next_req;
                    cnt     <= cnt + 6'h01;
                    acc_ap  <= next_req[SDP_REQ_AP];
                    req_rnw <= next_req[SDP_REQ_RNW];
                    acc_addr <= next_req[SDP_REQ_ADDR +: 2];
                    if (cnt == SDP_REQ_LAST)
                        // A malformed request gets no answer at all
                        state <= req_good ? ST_TURN_REQ : ST_LOCK;
                end
                ST_TURN_REQ:
                begin
                    // Undriven bit ends here; acknowledge starts now
                    if (refuse)
                        state <= ST_LOCK;
                    else
                    begin
                        state          <= ST_ACK;
                        ack            <= next_ack;
                        data_phase     <= next_data;
                        sh             <= {even_parity(rd_word), rd_word};
                        debug_data_out <= next_ack[0];
                        debug_data_oe  <= 1'b1;
                        cnt            <= 6'h00;
                        if (is_id)
                            port_active <= 1'b1;
                    end
                end
                ST_ACK:
                begin
                    cnt <= cnt + 6'h01;
                    if (cnt != SDP_ACK_LAST)
                        debug_data_out <= ack[cnt[1:0] + 2'h1];
                    else if (req_rnw && data_phase)
                    begin
                        state          <= ST_RDATA;
                        debug_data_out <= sh[0];
                        cnt            <= 6'h00;
                    end
                    else
                    begin
                        state          <= ST_TURN_ACK;
                        debug_data_oe  <= 1'b0;
                        debug_data_out <= 1'b1;
                    end
                end
                ST_TURN_ACK:
                begin
                    cnt   <= 6'h00;
                    state <= (!req_rnw && data_phase) ? ST_WDATA
                                                      : ST_IDLE;
                end
                ST_WDATA:
                begin
                    sh  <= next_sh;
                    cnt <= cnt + 6'h01;
                    if (cnt == SDP_DATA_LAST)
                        state <= ST_IDLE;
                end
                ST_RDATA:
                begin
                    sh  <= {1'b0, sh[32:1]};
                    cnt <= cnt + 6'h01;
                    if (cnt == SDP_DATA_LAST)
                    begin
                        state          <= ST_TURN_END;
                        debug_data_oe  <= 1'b0;
                        debug_data_out <= 1'b1;
                    end
                    else
                        debug_data_out <= sh[1];
                end
                ST_TURN_END:
                    state <= ST_IDLE;
                ST_LOCK:
                    state <= ST_LOCK;
            endcase
        end
    end

    //======================================================================
    // Core side strobes
    //======================================================================
    wire take_read  = rise && !line_reset && state == ST_TURN_REQ
                      && !refuse && req_rnw && !is_id && ack_ok;
    wire wdata_done = rise && !line_reset && state == ST_WDATA
                      && cnt == SDP_DATA_LAST;
    wire ack_was_ok = ack == SDP_ACK_OK;

    // Write parity failures after OK are flagged; an overrun data phase after WAIT or
    // FAULT is consumed with no core strobe, though its write data still lands on acc_wdata
    assign perr_set = wdata_done && !wr_par_ok && ack_was_ok;

    always_ff @(posedge clk)
    begin
        if (reset || !port_en)
        begin
            acc_write <= 1'b0;
            acc_read  <= 1'b0;
            acc_wdata <= 32'h0000_0000;
        end
        else
        begin
            acc_read  <= take_read;
            acc_write <= wdata_done && wr_par_ok && ack_was_ok;
            if (wdata_done)
                acc_wdata <= next_sh[31:0];
        end
    end

endmodule : sdp_port
`default_nettype wire

/* inc/sdp_pkg.sv */
// Constants and types shared by the serial wire debug port files
//==========================================================================
// Contract
// - Select bit 0 routes both debug pins to the port; 1 to GPIO/boot use.
// - Protection level 2 disables the port whatever the select bit says.
// - Level 3 disables port and boot-loader path; select 1 gives GPIO only.
// - During each one-cycle turnaround nobody drives; pull-up holds it high.
// - Every field goes least significant bit first.
// - Transfer: 8-bit request, 3-bit acknowledge, optional 33-bit data.
// - Request bit 5 is parity over bits 0-4; the device checks it.
// - Bit 6 is stop 0; park bit 7 is undriven and reads as 1.
// - One turnaround bit follows every request before the acknowledge.
// - Acknowledge bits first to last: 001 FAULT, 010 WAIT, 100 OK.
// - A turnaround bit follows the acknowledge, with nobody driving, except before read data.
// - Data phase: 32 data bits then a parity bit at position 32.
// - Data phase only after an OK acknowledge unless overrun detect is on.
// - With overrun detect on, data phase follows every acknowledge.
// - Port stays inactive until the identification register is read.
// - Reset state after power-on or more than 50 high link cycles.
// - From reset, two or more low cycles take the port to idle.
// - Not ready answers WAIT and ends; error answers FAULT and ends.
//==========================================================================
package sdp_pkg;

    // Register map of the plain register port
    localparam logic [3:0] SDP_REG_CTRL   = 4'h0;
    localparam logic [3:0] SDP_REG_STATUS = 4'h4;
    localparam logic [3:0] SDP_REG_CLEAR  = 4'h8;
    localparam int SDP_CTRL_SEL_BIT  = 0;
    localparam int SDP_CTRL_ORUN_BIT = 1;
    localparam int SDP_STAT_ACTIVE_BIT = 0;
    localparam int SDP_STAT_ENABLE_BIT = 1;
    localparam int SDP_STAT_PERR_BIT   = 2;
    localparam int SDP_CLEAR_PERR_BIT  = 0;
    localparam logic [1:0] SDP_CTRL_RESET = 2'h0;

    // Protection levels
    localparam logic [1:0] SDP_LEVEL_NO_PORT = 2'h2;
    localparam logic [1:0] SDP_LEVEL_LOCKED  = 2'h3;

    // Request field positions
    localparam int SDP_REQ_START  = 0;
    localparam int SDP_REQ_AP     = 1;
    localparam int SDP_REQ_RNW    = 2;
    localparam int SDP_REQ_ADDR   = 3;
    localparam int SDP_REQ_PARITY = 5;
    localparam int SDP_REQ_STOP   = 6;
    localparam int SDP_REQ_PARK   = 7;

    // Acknowledge codes, bit 0 sent first
    localparam logic [2:0] SDP_ACK_OK    = 3'h1;
    localparam logic [2:0] SDP_ACK_WAIT  = 3'h2;
    localparam logic [2:0] SDP_ACK_FAULT = 3'h4;

    // Counts in link clock cycles
    localparam logic [5:0] SDP_REQ_LAST   = 6'h07;
    localparam logic [5:0] SDP_ACK_LAST   = 6'h02;
    localparam logic [5:0] SDP_DATA_LAST  = 6'h20;
    localparam logic [5:0] SDP_LINE_RESET = 6'h32;
    localparam logic [1:0] SDP_IDLE_LOWS  = 2'h2;

    typedef enum logic [3:0] {
        ST_RESET,
        ST_IDLE,
        ST_REQ,
        ST_TURN_REQ,
        ST_ACK,
        ST_TURN_ACK,
        ST_WDATA,
        ST_RDATA,
        ST_TURN_END,
        ST_LOCK
    } sdp_state_t;

endpackage : sdp_pkg

/* logic/sdp_sync.sv */
// Three-stage pin synchroniser that accepts a change once stages agree
`timescale 1ns/10ps
`default_nettype none
module sdp_sync
    import sdp_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic pin,
    output logic      level
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s1    <= 1'b1;
            s2    <= 1'b1;
            s3    <= 1'b1;
            level <= 1'b1;
        end
        else
        begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                level <= s3;
        end
    end
endmodule : sdp_sync
`default_nettype wire

/* logic/sdp_regs.sv */
// Register port slave: control, status and sticky clear
`timescale 1ns/10ps
`default_nettype none
module sdp_regs
    import sdp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [31:0]      reg_rdata,
    output logic             pin_select,
    output logic             overrun_detect_enable,
    input  wire logic        port_active,
    input  wire logic        port_enable,
    input  wire logic        parity_error_set,
    output logic             parity_error
);
    logic [1:0] ctrl;
    wire        hit_ctrl   = reg_addr == SDP_REG_CTRL;
    wire        hit_status = reg_addr == SDP_REG_STATUS;
    wire        clear_perr = reg_write && reg_addr == SDP_REG_CLEAR
                             && reg_wdata[SDP_CLEAR_PERR_BIT];
    wire [31:0] status_word = {29'h0, parity_error, port_enable, port_active};
    wire [31:0] read_mux    = hit_ctrl   ? {30'h0, ctrl} :
                              hit_status ? status_word : 32'h0000_0000;

    assign pin_select            = ctrl[SDP_CTRL_SEL_BIT];
    assign overrun_detect_enable = ctrl[SDP_CTRL_ORUN_BIT];

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ctrl         <= SDP_CTRL_RESET;
            parity_error <= 1'b0;
            reg_rdata    <= 32'h0000_0000;
        end
        else
        begin
            if (reg_write && hit_ctrl)
                ctrl <= reg_wdata[1:0];
            // Set wins over a clear in the same cycle
            parity_error <= parity_error_set || (parity_error && !clear_perr);
            reg_rdata    <= reg_read ? read_mux : 32'h0000_0000;
        end
    end
endmodule : sdp_regs
`default_nettype wire

/* sim/sdp_port_chk.sv */
// Checker of pin enables, data line drive and core strobes
`timescale 1ns/10ps
`default_nettype none
module sdp_port_chk
    import sdp_pkg::*;
(
    input wire logic       clk,
    input wire logic       reset,
    input wire logic [1:0] prot_level,
    input wire logic       debug_data_out,
    input wire logic       debug_data_oe,
    input wire logic       debug_port_enable,
    input wire logic       gpio_pin_enable,
    input wire logic       boot_path_enable,
    input wire logic [3:0] reg_addr,
    input wire logic       reg_write,
    input wire logic       acc_write,
    input wire logic       acc_read,
    input wire logic       port_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    //==================
    // Sequences
    // Shortest drive is one link bit: eight clocks less sync jitter
    sequence s_drive_bit;
        debug_data_oe [*7];
    endsequence
    sequence s_answer_start;
        ##[0:2] debug_data_oe;
    endsequence
    //==================
    // Assertions
    AST_PORT_EN: assert property (
        debug_port_enable == (!gpio_pin_enable && prot_level < 2'h2))
        else $error("Debug port enable wrong");
    AST_BOOT_EN: assert property (
        boot_path_enable == (gpio_pin_enable && prot_level != 2'h3))
        else $error("Boot path enable wrong");
    AST_SEL_SRC: assert property (
        $changed(gpio_pin_enable) |->
            $past(reg_write) && $past(reg_addr) == SDP_REG_CTRL)
        else $error("Pin select moved without a control write");
    AST_IDLE_HIGH: assert property (!debug_data_oe |-> debug_data_out)
        else $error("Released data output not high");
    AST_OE_EN: assert property (debug_data_oe |-> debug_port_enable)
        else $error("Data line driven while port disabled");
    AST_HOLD_BIT: assert property ($rose(debug_data_oe) |-> s_drive_bit)
        else $error("Drive shorter than one link bit");
    AST_WR_PULSE: assert property (
        acc_write |=> !acc_write && !acc_read)
        else $error("Core write strobe longer than one cycle");
    AST_ACC_ACTIVE: assert property (
        (acc_write || acc_read) |-> port_active)
        else $error("Core access before activation");
    AST_ACT_ANSWER: assert property (
        $rose(port_active) |-> s_answer_start)
        else $error("Activation without an answer on the line");
endmodule : sdp_port_chk

bind sdp_port sdp_port_chk u_chk (
    .clk, .reset, .prot_level, .debug_data_out, .debug_data_oe,
    .debug_port_enable, .gpio_pin_enable, .boot_path_enable,
    .reg_addr, .reg_write, .acc_write, .acc_read, .port_active
);
`default_nettype wire

/* sim/sdp_host.sv */
// Debug probe model: makes the link clock and frames transfers
`timescale 1ns/10ps
`default_nettype none
module sdp_host
    import sdp_pkg::*;
(
    output logic      swclk,
    output logic      host_oe,
    output logic      host_out,
    input  wire logic line
);
    initial
    begin
        swclk = 1'b0;
        host_oe = 1'b0;
        host_out = 1'b1;
    end
    //==================
    // One link cycle; clock stands still between calls
    // Launch at the fall, sample just before the rise
    task automatic cyc(input logic d, input logic drv, output logic s);
        swclk <= 1'b0;
        host_oe <= drv;
        host_out <= d;
        #100;
        s = line;
        swclk <= 1'b1;
        #100;
    endtask : cyc
    task automatic line_reset();
        logic s;
        repeat (52) cyc(1'b1, 1'b0, s);
        repeat (2) cyc(1'b0, 1'b1, s);
    endtask : line_reset
    task automatic xfer(input logic ap, input logic rnw, input logic [1:0] a,
        input logic [31:0] wd, input logic [1:0] bad, input logic orun,
        output logic [2:0] ack, output logic [31:0] rd, output logic rp);
        logic [7:0] rq;
        logic       s;
        rq = {2'h2, ^{a, rnw, ap, 1'b1} ^ bad[0], a, rnw, ap, 1'b1};
        rd = '0;
        rp = 1'b0;
        for (int i = 0; i < 7; i++) cyc(rq[i], 1'b1, s);
        cyc(1'b1, 1'b0, s);
        cyc(1'b1, 1'b0, s);
        for (int i = 0; i < 3; i++) cyc(1'b1, 1'b0, ack[i]);
        if (ack == SDP_ACK_OK || orun)
        begin
            if (rnw)
            begin
                for (int i = 0; i < 32; i++) cyc(1'b1, 1'b0, rd[i]);
                cyc(1'b1, 1'b0, rp);
                cyc(1'b1, 1'b0, s);
            end
            else
            begin
                cyc(1'b1, 1'b0, s);
                for (int i = 0; i < 32; i++) cyc(wd[i], 1'b1, s);
                cyc(^wd ^ bad[1], 1'b1, s);
                repeat (2) cyc(1'b0, 1'b1, s);
            end
        end
        else
            cyc(1'b1, 1'b0, s);
        host_oe <= 1'b0;
    endtask : xfer
endmodule : sdp_host
`default_nettype wire

/* sim/test_sdp_port.sv */
// Self-checking bench for the serial wire debug port
`timescale 1ns/10ps
`default_nettype none
module test_sdp_port
    import sdp_pkg::*;
;
    // Arbitrary identification value
    localparam logic [31:0] ID = 32'h3C5A_96E1;
    localparam logic [31:0] RV = 32'h8001_7FFE;
    logic        clk, reset, debug_clock_pin, host_oe, host_out;
    logic        debug_data_in, debug_data_out, debug_data_oe;
    logic        debug_port_enable, gpio_pin_enable, boot_path_enable;
    logic [1:0]  prot_level, acc_addr;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, acc_wdata, core_rdata, rd, v;
    logic        reg_write, reg_read, acc_write, acc_read, acc_ap;
    logic        core_ready, core_fault, port_active, rp, orun;
    logic [2:0]  ack;
    int          miscompares, tests_run, n_wr, n_rd;
    // Pull-up wins whenever nobody drives
    assign debug_data_in = host_oe ? host_out :
                           debug_data_oe ? debug_data_out : 1'b1;
    sdp_port #(.ID_VALUE(ID)) dut (
        .clk, .reset, .prot_level, .debug_clock_pin, .debug_data_in,
        .debug_data_out, .debug_data_oe, .debug_port_enable,
        .gpio_pin_enable, .boot_path_enable, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .acc_write, .acc_read, .acc_ap,
        .acc_addr, .acc_wdata, .core_ready, .core_fault, .core_rdata,
        .port_active);
    sdp_host u_host (.swclk(debug_clock_pin), .host_oe, .host_out,
                     .line(debug_data_in));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        n_wr <= n_wr + int'(acc_write);
        n_rd <= n_rd + int'(acc_read);
    end
    //==================
    // Tasks
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask : rdr
    task automatic core(input logic r, input logic f);
        @(posedge clk);
        core_ready <= r;
        core_fault <= f;
    endtask : core
    task automatic go(input logic ap, input logic rnw, input logic [1:0] a,
                      input logic [31:0] wd, input logic [1:0] bad);
        u_host.xfer(ap, rnw, a, wd, bad, orun, ack, rd, rp);
        repeat (4) @(posedge clk);
    endtask : go
    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        #2ms;
        miscompares++;
        tally_and_finish();
    end
    //==================
    // Main sequence
    initial
    begin
        {reset, reg_write, reg_read, core_ready, core_fault, orun} = 6'h20;
        {prot_level, reg_addr, reg_wdata} = '0;
        {miscompares, tests_run, n_wr, n_rd} = '0;
        core_rdata = RV;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            wr(SDP_REG_CTRL, 32'(i[0]));
            @(posedge clk);
            prot_level <= i[2:1];
            @(posedge clk);
            #1;
            chk("port", 32'(!i[0] && i[2:1] < 2), 32'(debug_port_enable));
            chk("gpio", 32'(i[0]), 32'(gpio_pin_enable));
            chk("boot", 32'(i[0] && i[2:1] != 3), 32'(boot_path_enable));
        end
        wr(SDP_REG_CTRL, 32'h0000_0000);
        prot_level <= 2'h0;
        wr(SDP_REG_STATUS, 32'hFFFF_FFFF);
        rdr(SDP_REG_STATUS, v);
        chk("status", 32'h0000_0002, v);
        rdr(4'hC, v);
        chk("unmapped", 32'h0000_0000, v);
        core(1'b1, 1'b0);
        u_host.line_reset();
        go(1'b0, 1'b1, 2'h1, 32'h0000_0000, 2'h0);
        chk("ack early", 32'h0000_0007, 32'(ack));
        u_host.line_reset();
        go(1'b0, 1'b1, 2'h0, 32'h0000_0000, 2'h0);
        chk("ack id", 32'(SDP_ACK_OK), 32'(ack));
        chk("id", ID, rd);
        chk("id parity", 32'(^ID), 32'(rp));
        rdr(SDP_REG_STATUS, v);
        chk("active", 32'h0000_0003, v);
        go(1'b1, 1'b0, 2'h2, 32'hA5C3_0F96, 2'h0);
        chk("ack wr", 32'(SDP_ACK_OK), 32'(ack));
        chk("writes", 32'h0000_0001, 32'(n_wr));
        chk("wdata", 32'hA5C3_0F96, acc_wdata);
        chk("ap addr", 32'h0000_0006, 32'({acc_ap, acc_addr}));
        go(1'b1, 1'b1, 2'h3, 32'h0000_0000, 2'h0);
        chk("rdata", RV, rd);
        chk("rparity", 32'(^RV), 32'(rp));
        chk("reads", 32'h0000_0001, 32'(n_rd));
        core(1'b0, 1'b0);
        go(1'b1, 1'b1, 2'h3, 32'h0000_0000, 2'h0);
        chk("ack wait", 32'(SDP_ACK_WAIT), 32'(ack));
        core(1'b1, 1'b1);
        go(1'b1, 1'b0, 2'h1, 32'h0000_00FF, 2'h0);
        chk("ack fault", 32'(SDP_ACK_FAULT), 32'(ack));
        wr(SDP_REG_CTRL, 32'h0000_0002);
        orun = 1'b1;
        core(1'b0, 1'b0);
        go(1'b1, 1'b1, 2'h0, 32'h0000_0000, 2'h0);
        chk("orun rd", 32'h0000_0000, rd ^ 32'(rp));
        go(1'b1, 1'b0, 2'h0, 32'h1357_9BDF, 2'h0);
        chk("orun wr", 32'(SDP_ACK_WAIT), 32'(ack));
        chk("writes", 32'h0000_0001, 32'(n_wr));
        wr(SDP_REG_CTRL, 32'h0000_0000);
        orun = 1'b0;
        core(1'b1, 1'b0);
        go(1'b0, 1'b0, 2'h2, 32'h0F0F_0001, 2'h2);
        chk("writes", 32'h0000_0001, 32'(n_wr));
        rdr(SDP_REG_STATUS, v);
        chk("perr", 32'h0000_0007, v);
        wr(SDP_REG_CLEAR, 32'h0000_0001);
        rdr(SDP_REG_STATUS, v);
        chk("perr clr", 32'h0000_0003, v);
        go(1'b0, 1'b1, 2'h0, 32'h0000_0000, 2'h1);
        chk("bad req", 32'h0000_0007, 32'(ack));
        go(1'b0, 1'b1, 2'h0, 32'h0000_0000, 2'h0);
        chk("locked", 32'h0000_0007, 32'(ack));
        u_host.line_reset();
        rdr(SDP_REG_STATUS, v);
        chk("reset", 32'h0000_0002, v);
        go(1'b0, 1'b1, 2'h0, 32'h0000_0000, 2'h0);
        chk("ack id", 32'(SDP_ACK_OK), 32'(ack));
        core(1'b1, 1'b0);
        prot_level <= SDP_LEVEL_NO_PORT;
        go(1'b0, 1'b1, 2'h0, 32'h0000_0000, 2'h0);
        chk("level 2", 32'h0000_0007, 32'(ack));
        tally_and_finish();
    end
endmodule : test_sdp_port
`default_nettype wire
